// ==== verilog/adcctl_top.sv ====
// converter trigger and channel control with apb register access
// Function
// - codes 01000-01111, 11000-11011 pick external inputs
// - 11101 high ref, 11110 low ref, 11111 disable
// - active bit set at start, cleared at end
// - software mode starts on first register write
// - hardware mode starts on trigger input assertion
`timescale 1ns/1ns
`include "adcctl_map.svh"
module adcctl_top
   import adcctl_pkg::*;
#(
   parameter int CONV_CYCLES = `ADCCTL_CONV_CYCLES
)
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger source
   input wire logic hw_trigger_input,
   // converter side
   input wire logic conv_complete,
   output logic [27:0] ext_select,
   output logic high_reference_level,
   output logic low_reference_level,
   output logic module_disabled,
   output logic conv_start,
   output logic conversion_active_flag
);
   // refuse counts the 16-bit conversion counter cannot reach
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_conv_cycles_check
      $error("CONV_CYCLES out of range");
   end

   localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

   logic [7:0] status_control_first_r;
   logic [7:0] status_control_second_r;
   logic trig_meta_r;
   logic trig_sync_r;
   logic trig_prev_r;
   logic conv_done_r;
   logic [15:0] cnt_r;
   logic [31:0] prdata_r;
   adcctl_state_type state_r;
   adcctl_state_type state_nxt;
   logic [27:0] ext_sel_c;
   adcctl_src_type src_c;
   logic dis_c;
   logic rsv_c;
   logic wr_acc;
   logic rd_acc;
   logic sc1_wr;
   logic abort_c;
   logic sw_go;
   logic hw_go;
   logic start_c;
   logic finish_c;
   logic hw_mode;
   // decoded register selects and images
   logic sc1_sel;
   logic sc2_sel;
   logic stat_sel;
   logic sc2_wr;
   logic rd_setup;
   logic new_chan_blocked;
   logic cur_chan_blocked;
   logic trig_rise;
   logic in_conv;
   logic conv_timeout;
   logic [7:0] sc1_word;
   logic [7:0] sc2_word;
   logic [7:0] stat_word;
   logic [31:0] rd_word;

   // register select from a byte address
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
      reg_hit = (a == off);
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = reg_hit(a, `ADCCTL_OFF_SC1) || reg_hit(a, `ADCCTL_OFF_SC2) ||
                reg_hit(a, `ADCCTL_OFF_STAT);
   endfunction

   // channel codes that must never start a conversion
   function automatic logic chan_blocked(input logic [4:0] ch);
      chan_blocked = (ch == `ADCCTL_CH_OFF) || (ch == `ADCCTL_CH_RSV);
   endfunction

   // widen an 8-bit register image to the bus word
   function automatic logic [31:0] bus_word(input logic [7:0] b);
      bus_word = {24'h000000, b};
   endfunction

   adcctl_chan_dec u_dec (
      .input_channel_field(status_control_first_r[`ADCCTL_CH_MSB:`ADCCTL_CH_LSB]),
      .ext_select(ext_sel_c),
      .source(src_c),
      .module_disabled(dis_c),
      .reserved_code(rsv_c)
   );

   // apb decode: zero wait states, writes land at the access edge
   assign sc1_sel = reg_hit(paddr, `ADCCTL_OFF_SC1);
   assign sc2_sel = reg_hit(paddr, `ADCCTL_OFF_SC2);
   assign stat_sel = reg_hit(paddr, `ADCCTL_OFF_STAT);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign sc1_wr = wr_acc && sc1_sel;
   assign sc2_wr = wr_acc && sc2_sel;
   assign hw_mode = status_control_second_r[`ADCCTL_TRG_BIT];

   // first register: channel field and abort bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_control_first_r <= `ADCCTL_SC1_RST;
      end else if (sc1_wr) begin
         status_control_first_r <= pwdata[7:0];
      end
   end

   // second register: trigger select and compare controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_control_second_r <= `ADCCTL_SC2_RST;
      end else if (sc2_wr) begin
         status_control_second_r <= pwdata[7:0] & `ADCCTL_SC2_WMASK;
      end
   end

   // two-stage synchroniser for the asynchronous trigger pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_meta_r <= 1'b0;
         trig_sync_r <= 1'b0;
      end else begin
         trig_meta_r <= hw_trigger_input;
         trig_sync_r <= trig_meta_r;
      end
   end

   // edge history resets to the idle pin level, so no false edge after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_sync_r;
      end
   end

   // a software start is judged on the channel being written, not the one it replaces
   assign new_chan_blocked = chan_blocked(pwdata[`ADCCTL_CH_MSB:`ADCCTL_CH_LSB]);
   assign cur_chan_blocked = chan_blocked(status_control_first_r[`ADCCTL_CH_MSB:`ADCCTL_CH_LSB]);
   assign trig_rise = trig_sync_r && !trig_prev_r;

   assign sw_go = !hw_mode && sc1_wr && !pwdata[`ADCCTL_SC1_ABORT_BIT] && !new_chan_blocked;
   assign hw_go = hw_mode && trig_rise && !cur_chan_blocked;
   // any other write to the first register, or a disabled channel, ends a conversion
   assign abort_c = sc1_wr || dis_c;
   assign start_c = sw_go || hw_go;

   // internal timeout in case the converter never reports completion
   assign in_conv = (state_r == ADCCTL_CONV);
   assign conv_timeout = in_conv && (cnt_r == CONV_LAST);
   assign finish_c = conv_complete || conv_timeout;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ADCCTL_IDLE: begin
            if (start_c) begin
               state_nxt = ADCCTL_CONV;
            end
         end
         ADCCTL_CONV: begin
            // a fresh start restarts the count; abort outranks completion
            if (start_c) begin
               state_nxt = ADCCTL_CONV;
            end else if (abort_c) begin
               state_nxt = ADCCTL_IDLE;
            end else if (finish_c) begin
               state_nxt = ADCCTL_DONE;
            end
         end
         ADCCTL_DONE: begin
            // one cycle for the sticky done bit, unless a start follows at once
            if (start_c) begin
               state_nxt = ADCCTL_CONV;
            end else begin
               state_nxt = ADCCTL_IDLE;
            end
         end
         default: state_nxt = ADCCTL_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ADCCTL_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // conversion cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
      end else if (start_c || !in_conv) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // sticky completion status, cleared by next start
   // completion wins over a start landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done_r <= 1'b0;
      end else if (state_r == ADCCTL_DONE) begin
         conv_done_r <= 1'b1;
      end else if (start_c) begin
         conv_done_r <= 1'b0;
      end
   end

   assign conversion_active_flag = (state_r == ADCCTL_CONV);
   assign conv_start = start_c;
   assign ext_select = ext_sel_c;

   // reference routing follows the decoded source
   always_comb begin
      high_reference_level = 1'b0;
      low_reference_level = 1'b0;
      case (src_c)
         ADCCTL_SRC_REFH: high_reference_level = 1'b1;
         ADCCTL_SRC_REFL: low_reference_level = 1'b1;
         default: high_reference_level = 1'b0;
      endcase
   end

   assign module_disabled = dis_c;

   // register images as software sees them
   assign sc1_word = status_control_first_r;

   // active bit comes from the state machine, never from the stored byte
   always_comb begin
      sc2_word = status_control_second_r;
      sc2_word[`ADCCTL_ACT_BIT] = conversion_active_flag;
   end

   always_comb begin
      stat_word = 8'h00;
      stat_word[`ADCCTL_STAT_DONE_BIT] = conv_done_r;
      stat_word[`ADCCTL_STAT_DIS_BIT] = dis_c;
      stat_word[`ADCCTL_STAT_RSV_BIT] = rsv_c;
   end

   // read word selection; unmapped addresses read zero
   always_comb begin
      rd_word = 32'h00000000;
      if (sc1_sel) begin
         rd_word = bus_word(sc1_word);
      end else if (sc2_sel) begin
         rd_word = bus_word(sc2_word);
      end else if (stat_sel) begin
         rd_word = bus_word(stat_word);
      end
   end

   // read data captured in the setup cycle and held through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_r <= rd_word;
      end
   end

   // prdata shows the captured word only during a read access
   assign prdata = rd_acc ? prdata_r : 32'h00000000;
endmodule // adcctl_top

// ==== verilog/adcctl_map.svh ====
// register offsets, field positions and reset values of the converter control block
`ifndef ADCCTL_MAP_SVH
`define ADCCTL_MAP_SVH
`define ADCCTL_OFF_SC1 12'h000
`define ADCCTL_OFF_SC2 12'h004
`define ADCCTL_OFF_STAT 12'h008
`define ADCCTL_OFF_END 12'h00c
`define ADCCTL_SC1_RST 8'h1f
`define ADCCTL_SC2_RST 8'h00
`define ADCCTL_CH_LSB 0
`define ADCCTL_CH_MSB 4
`define ADCCTL_SC1_ABORT_BIT 5
`define ADCCTL_ACT_BIT 7
`define ADCCTL_TRG_BIT 6
`define ADCCTL_SC2_WMASK 8'h7c
`define ADCCTL_STAT_DONE_BIT 0
`define ADCCTL_STAT_DIS_BIT 1
`define ADCCTL_STAT_RSV_BIT 2
`define ADCCTL_CH_EXT_LO 5'h08
`define ADCCTL_CH_EXT_HI 5'h0f
`define ADCCTL_CH_HIGH_LO 5'h18
`define ADCCTL_CH_HIGH_HI 5'h1b
`define ADCCTL_CH_RSV 5'h1c
`define ADCCTL_CH_REFH 5'h1d
`define ADCCTL_CH_REFL 5'h1e
`define ADCCTL_CH_OFF 5'h1f
`define ADCCTL_HIGH_BASE 5'h18
`define ADCCTL_EXT_BASE 5'h08
`define ADCCTL_CONV_CYCLES 16'd23
`endif

// ==== verilog/adcctl_pkg.sv ====
// types shared by the converter control block
package adcctl_pkg;
   typedef enum logic [2:0] {
      ADCCTL_IDLE = 3'b001,
      ADCCTL_CONV = 3'b010,
      ADCCTL_DONE = 3'b100
   } adcctl_state_type;
   typedef enum logic [2:0] {
      ADCCTL_SRC_NONE = 3'h0,
      ADCCTL_SRC_EXT = 3'h1,
      ADCCTL_SRC_REFH = 3'h2,
      ADCCTL_SRC_REFL = 3'h3,
      ADCCTL_SRC_OFF = 3'h4
   } adcctl_src_type;
endpackage

// ==== verilog/adcctl_chan_dec.sv ====
// channel field decoder: external input select, references, disable
`timescale 1ns/1ns
`include "adcctl_map.svh"
module adcctl_chan_dec
   import adcctl_pkg::*;
(
   // channel field
   input wire logic [4:0] input_channel_field,
   // decoded outputs
   output logic [27:0] ext_select,
   output adcctl_src_type source,
   output logic module_disabled,
   output logic reserved_code
);
   always_comb begin
      ext_select = 28'h0000000;
      source = ADCCTL_SRC_NONE;
      module_disabled = 1'b0;
      reserved_code = 1'b0;
      if (input_channel_field >= `ADCCTL_CH_EXT_LO && input_channel_field <= `ADCCTL_CH_EXT_HI) begin
         ext_select[input_channel_field] = 1'b1;
         source = ADCCTL_SRC_EXT;
      end else if (input_channel_field >= `ADCCTL_CH_HIGH_LO &&
                   input_channel_field <= `ADCCTL_CH_HIGH_HI) begin
         ext_select[input_channel_field] = 1'b1;
         source = ADCCTL_SRC_EXT;
      end else begin
         case (input_channel_field)
            `ADCCTL_CH_REFH: source = ADCCTL_SRC_REFH;
            `ADCCTL_CH_REFL: source = ADCCTL_SRC_REFL;
            `ADCCTL_CH_OFF: begin
               source = ADCCTL_SRC_OFF;
               module_disabled = 1'b1;
            end
            `ADCCTL_CH_RSV: reserved_code = 1'b1;
            default: source = ADCCTL_SRC_NONE;
         endcase
      end
   end
endmodule // adcctl_chan_dec

// ==== sim/adcctl_trig_src.sv ====
// hardware trigger source model
`timescale 1ns/1ns
module adcctl_trig_src (
   // clock, reset, request
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fire,
   // trigger pin
   output logic hw_trigger_input
);
   logic [1:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 2'h0;
      else if (fire) cnt_r <= 2'h3;
      else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
   end
   assign hw_trigger_input = (cnt_r != 2'h0);
endmodule // adcctl_trig_src

// ==== sim/adcctl_top_chk.sv ====
// assertions on the converter control block ports
`timescale 1ns/1ns
module adcctl_top_chk (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // trigger and converter
   input wire logic hw_trigger_input,
   input wire logic conv_complete,
   input wire logic [27:0] ext_select,
   input wire logic high_reference_level,
   input wire logic low_reference_level,
   input wire logic module_disabled,
   input wire logic conv_start,
   input wire logic conversion_active_flag
);
   logic trg_r;
   wire logic acc = psel && penable && pwrite;
   wire logic [4:0] ch = pwdata[4:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) trg_r <= 1'b0;
      else if (acc && paddr == 12'h004) trg_r <= pwdata[6];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence sc1_wr;
      acc && paddr == 12'h000;
   endsequence
   chk_start_sets_act: assert property (conv_start |=> conversion_active_flag)
      else $error("active flag not set after start");
   chk_done_clears_act: assert property ((conversion_active_flag && conv_complete && !conv_start)
      |=> !conversion_active_flag)
      else $error("active flag not cleared on completion");
   chk_act_needs_start: assert property ($rose(conversion_active_flag) |-> $past(conv_start))
      else $error("active flag rose without start");
   chk_act_read_only: assert property ((acc && paddr == 12'h004 && !conversion_active_flag
      && !conv_start) |=> !conversion_active_flag)
      else $error("register write changed active flag");
   chk_sw_start: assert property ((sc1_wr ##0 (!trg_r && !pwdata[5] && ch != 5'h1f
      && ch != 5'h1c)) |-> conv_start)
      else $error("no start on first register write");
   chk_hw_start: assert property ((trg_r && !module_disabled && $rose(hw_trigger_input))
      |-> ##[1:4] conv_start)
      else $error("no start after trigger");
   chk_ext_select: assert property ((sc1_wr ##0 (ch inside {[8:15], [24:27]}))
      |=> ext_select == 28'h1 << $past(ch))
      else $error("external input decode wrong");
   chk_refh_code: assert property ((sc1_wr ##0 ch == 5'h1d)
      |=> high_reference_level && !low_reference_level && !module_disabled)
      else $error("high reference decode wrong");
   chk_off_code: assert property ((sc1_wr ##0 ch == 5'h1f)
      |=> module_disabled && ext_select == 28'h0 && !high_reference_level)
      else $error("disable decode wrong");
endmodule // adcctl_top_chk

// ==== sim/test_adc_channel_trigger_control.sv ====
// bench for the converter control block
`timescale 1ns/1ns
module test_adc_channel_trigger_control;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_complete = 0, fire = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, st, hw_trigger_input, high_reference_level, low_reference_level;
   logic module_disabled, conv_start, conversion_active_flag;
   logic [27:0] ext_select;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   // long enough that conv_complete, not the internal timeout, ends the first conversion in t_sw
   localparam int CONV_N = 12;
   adcctl_top #(.CONV_CYCLES(CONV_N)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hw_trigger_input, .conv_complete, .ext_select,
      .high_reference_level, .low_reference_level, .module_disabled, .conv_start,
      .conversion_active_flag);
   adcctl_trig_src src (.pclk, .presetn, .fire, .hw_trigger_input);
   initial forever #4 pclk = ~pclk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      st = conv_start;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic t_reset;
      apb(0, 12'h000, 0);
      chk("sc1 reset", 32'h1f, rd);
      chk("disabled", 1, module_disabled);
      apb(0, 12'h004, 0);
      chk("sc2 reset", 0, rd);
      apb(0, 12'h00c, 0);
      chk("unmapped", 1, er);
      $display("test reset done");
   endtask
   task automatic t_codes;
      for (int c = 8; c < 32; c++) begin
         if (c < 16 || c > 23) begin
            apb(1, 12'h000, c);
            #1;
            chk("ext", (c < 28) ? 1 << c : 0, ext_select);
            chk("refh", c == 29, high_reference_level);
            chk("refl", c == 30, low_reference_level);
            chk("off", c == 31, module_disabled);
            if (c == 28) begin
               apb(0, 12'h008, 0);
               chk("status rsv", 32'h4, rd);
            end
         end
      end
      apb(0, 12'h008, 0);
      chk("status off", 32'h2, rd);
      $display("test codes done");
   endtask
   task automatic t_sw;
      int n;
      apb(1, 12'h000, 32'h08);
      chk("start pulse", 1, st);
      #1;
      chk("act set", 1, conversion_active_flag);
      apb(0, 12'h004, 0);
      chk("act bit", 32'h80, rd);
      @(posedge pclk) conv_complete <= 1;
      @(posedge pclk) conv_complete <= 0;
      #1;
      chk("act clr", 0, conversion_active_flag);
      apb(0, 12'h008, 0);
      chk("status done", 32'h1, rd);
      apb(1, 12'h004, 32'h80);
      apb(0, 12'h004, 0);
      chk("act ro", 0, rd);
      apb(1, 12'h000, 32'h08);
      // no completion: active stays high CONV_N edges, the start edge included
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         #1;
         if (conversion_active_flag !== 1'b1) break;
      end
      chk("timeout", CONV_N - 1, n);
      $display("test software done");
   endtask
   task automatic t_hw;
      apb(1, 12'h004, 32'h40);
      apb(1, 12'h000, 32'h08);
      chk("no sw pulse", 0, st);
      #1;
      chk("no sw start", 0, conversion_active_flag);
      @(posedge pclk) fire <= 1;
      @(posedge pclk) fire <= 0;
      for (int i = 0; i < 8 && conversion_active_flag !== 1'b1; i++) begin
         @(posedge pclk);
         #1;
      end
      chk("hw act", 1, conversion_active_flag);
      apb(1, 12'h004, 32'h40);
      apb(0, 12'h004, 0);
      chk("act ro busy", 32'hc0, rd);
      $display("test hardware done");
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_codes;
      t_sw;
      t_hw;
      report_and_stop;
   end
endmodule // test_adc_channel_trigger_control
bind adcctl_top adcctl_top_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .hw_trigger_input, .conv_complete, .ext_select, .high_reference_level,
   .low_reference_level, .module_disabled, .conv_start, .conversion_active_flag);
